// ===== hw/fpsc_top.v
// Purpose: flash program store control: write/erase routing, cache enables, read strobe
// Assumes: core gives a one-cycle sfr write/read strobe and a one-cycle move write strobe
// Notes: flash array itself lives outside; this block drives its control pins
//
// Contract
// - write enable set with erase clear routes each move write to a one-byte flash program.
// - erase and write enable both set turn a move write into page erase.
// - write enable clear means move writes never reach the flash.
// - program store control bits 7 to 2 read zero, writes ignored.
// - four-bit strobe period bounds the flash read strobe width, resets 0xf.
// - after the read strobe drops, flash sits in low power that cycle.
// - period ignored when clock exceeds 12.5 MHz and timing select is zero.
// - strobe period register bits 7 to 4 read zero, writes ignored.
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_regs.vh"

module fpsc_top (
    input wire clk,
    input wire rst,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata_q,
    input wire move_wr,
    input wire [16:0] move_addr,
    input wire [7:0] move_wdata,
    input wire flash_read_req,
    input wire flash_read_timing_select,
    output reg flash_prog_q,
    output reg flash_erase_q,
    output reg [16:0] flash_addr_q,
    output reg [7:0] flash_wdata_q,
    output reg xdata_wr_q,
    output reg flash_rd_strobe_q,
    output reg flash_low_power_q,
    output reg prefetch_engine_enable_q,
    output reg block_write_enable_q
);

    // ---------------------------------------------------------------
    // derived timing
    // ---------------------------------------------------------------
    // set when the clock rate is above the slow-clock threshold; timing select does not enter it
    localparam FAST_CLK = (`FPSC_CLK_KHZ > `FPSC_SLOW_CLK_KHZ);

    // reset images; the reserved cache bits have no flops behind them
    localparam [1:0] PSC_RST = `FPSC_PSC_RST;
    localparam [7:0] CACHE_RST = `FPSC_CACHE_RST;

    // sfr select codes
    localparam [1:0] SEL_NONE = 2'h0;
    localparam [1:0] SEL_PSC = 2'h1;
    localparam [1:0] SEL_STROBE = 2'h2;
    localparam [1:0] SEL_CACHE = 2'h3;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    // one decode shared by write and read paths, so the two never disagree
    function [1:0] sfr_sel;
        input [7:0] addr;
        begin
            if (addr == `FPSC_ADDR_PSC) begin
                sfr_sel = SEL_PSC;
            end else if (addr == `FPSC_ADDR_STROBE) begin
                sfr_sel = SEL_STROBE;
            end else if (addr == `FPSC_ADDR_CACHE) begin
                sfr_sel = SEL_CACHE;
            end else begin
                sfr_sel = SEL_NONE;
            end
        end
    endfunction

    // select code of the current sfr address
    wire [1:0] sfr_hit;
    assign sfr_hit = sfr_sel(sfr_addr);

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    reg store_write_enable_q;
    reg page_erase_enable_q;
    reg [3:0] strobe_period_q;
    reg [3:0] strobe_cnt_q;
    reg [3:0] strobe_cnt_d;
    reg strobe_d;
    reg strobe_done_q;
    reg strobe_done_d;

    // sfr writes; unused bits have no storage so writes there vanish
    always @(posedge clk) begin
        if (rst) begin
            store_write_enable_q <= PSC_RST[`FPSC_PSC_WE_BIT];
            page_erase_enable_q <= PSC_RST[`FPSC_PSC_EE_BIT];
            strobe_period_q <= `FPSC_STROBE_RST;
            prefetch_engine_enable_q <= CACHE_RST[`FPSC_CACHE_PF_BIT];
            block_write_enable_q <= CACHE_RST[`FPSC_CACHE_BLK_BIT];
        end else if (sfr_wr) begin
            if (sfr_hit == SEL_PSC) begin
                store_write_enable_q <= sfr_wdata[`FPSC_PSC_WE_BIT];
                page_erase_enable_q <= sfr_wdata[`FPSC_PSC_EE_BIT];
            end else if (sfr_hit == SEL_STROBE) begin
                strobe_period_q <= sfr_wdata[`FPSC_PERIOD_MSB:`FPSC_PERIOD_LSB];
            end else if (sfr_hit == SEL_CACHE) begin
                prefetch_engine_enable_q <= sfr_wdata[`FPSC_CACHE_PF_BIT];
                block_write_enable_q <= sfr_wdata[`FPSC_CACHE_BLK_BIT];
            end
        end
    end

    // reserved cache bits read zero; only the two live bits are stored
    reg [7:0] cache_view;
    always @* begin
        cache_view = `FPSC_ZERO8;
        cache_view[`FPSC_CACHE_PF_BIT] = prefetch_engine_enable_q;
        cache_view[`FPSC_CACHE_BLK_BIT] = block_write_enable_q;
    end

    // read data, registered; unmapped addresses return zero
    always @(posedge clk) begin
        if (rst) begin
            sfr_rdata_q <= `FPSC_ZERO8;
        end else if (sfr_rd) begin
            if (sfr_hit == SEL_PSC) begin
                sfr_rdata_q <= {`FPSC_PSC_PAD, page_erase_enable_q, store_write_enable_q};
            end else if (sfr_hit == SEL_STROBE) begin
                sfr_rdata_q <= {`FPSC_STROBE_PAD, strobe_period_q};
            end else if (sfr_hit == SEL_CACHE) begin
                sfr_rdata_q <= cache_view & `FPSC_CACHE_MASK;
            end else begin
                sfr_rdata_q <= `FPSC_ZERO8;
            end
        end
    end

    // ---------------------------------------------------------------
    // move write routing
    // ---------------------------------------------------------------
    // each move write becomes one one-cycle command (flash program, page erase or xdata write); grouping of
    // bytes under block write is left to the flash array controller
    always @(posedge clk) begin
        if (rst) begin
            flash_prog_q <= 1'b0;
            flash_erase_q <= 1'b0;
            xdata_wr_q <= 1'b0;
            flash_addr_q <= `FPSC_ADDR_RST;
            flash_wdata_q <= `FPSC_ZERO8;
        end else begin
            flash_prog_q <= 1'b0;
            flash_erase_q <= 1'b0;
            xdata_wr_q <= 1'b0;
            if (move_wr) begin
                flash_addr_q <= move_addr;
                flash_wdata_q <= move_wdata;
                if (store_write_enable_q && page_erase_enable_q) begin
                    flash_erase_q <= 1'b1;
                end else if (store_write_enable_q) begin
                    flash_prog_q <= 1'b1;
                end else begin
                    xdata_wr_q <= 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // read strobe one-shot
    // ---------------------------------------------------------------
    // width = period+1 cycles; with the fast clock and no timing select
    // the strobe simply follows the request, the period unused
    always @* begin
        strobe_cnt_d = strobe_cnt_q;
        strobe_d = 1'b0;
        strobe_done_d = strobe_done_q;
        if (flash_read_req) begin
            if (FAST_CLK && !flash_read_timing_select) begin
                strobe_d = 1'b1;
                strobe_cnt_d = `FPSC_ZERO4;
                strobe_done_d = 1'b0;
            end else if (!flash_rd_strobe_q && !strobe_done_q &&
                         strobe_cnt_q == `FPSC_ZERO4) begin
                strobe_d = 1'b1;
                strobe_cnt_d = strobe_period_q;
            end else if (strobe_cnt_q != `FPSC_ZERO4) begin
                strobe_d = 1'b1;
                strobe_cnt_d = strobe_cnt_q - `FPSC_ONE4;
            end else if (flash_rd_strobe_q) begin
                strobe_done_d = 1'b1;
            end
        end else begin
            // request low re-arms the one-shot
            strobe_cnt_d = `FPSC_ZERO4;
            strobe_done_d = 1'b0;
        end
    end

    // a held request would otherwise restrike the strobe one cycle after it drops
    always @(posedge clk) begin
        if (rst) begin
            strobe_cnt_q <= `FPSC_ZERO4;
            strobe_done_q <= 1'b0;
            flash_rd_strobe_q <= 1'b0;
            flash_low_power_q <= 1'b1;
        end else begin
            strobe_cnt_q <= strobe_cnt_d;
            strobe_done_q <= strobe_done_d;
            flash_rd_strobe_q <= strobe_d;
            flash_low_power_q <= ~strobe_d;
        end
    end

endmodule // fpsc_top
`default_nettype wire

// ===== hw/fpsc_regs.vh
// Purpose: register map and timing constants for the flash program store control
// Assumes: 8-bit special-function register port, 40 MHz system clock
// Notes: definitions only
`ifndef FPSC_REGS_VH
`define FPSC_REGS_VH
`define FPSC_ADDR_PSC 8'h8f
`define FPSC_ADDR_STROBE 8'hbe
`define FPSC_ADDR_CACHE 8'he3
`define FPSC_PSC_WE_BIT 0
`define FPSC_PSC_EE_BIT 1
`define FPSC_CACHE_BLK_BIT 0
`define FPSC_CACHE_PF_BIT 5
`define FPSC_PSC_RST 2'h0
`define FPSC_STROBE_RST 4'hf
`define FPSC_CACHE_RST 8'h20
`define FPSC_CACHE_MASK 8'h21
`define FPSC_SLOW_CLK_KHZ 12500
`define FPSC_CLK_KHZ 40000
`define FPSC_OP_NONE 2'h0
`define FPSC_OP_WRITE 2'h1
`define FPSC_OP_ERASE 2'h2
`define FPSC_ZERO8 8'h00
`define FPSC_ONE4 4'h1
`define FPSC_PERIOD_MSB 3
`define FPSC_PERIOD_LSB 0
`define FPSC_PSC_PAD 6'h00
`define FPSC_STROBE_PAD 4'h0
`define FPSC_ADDR_RST 17'h00000
`define FPSC_ZERO4 4'h0
`endif

// ===== dv/fpsc_chk_sva.sv
// Purpose: port checks for fpsc_top
// Assumes: one clock, sync active-high rst
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module fpsc_chk (
    input wire logic clk, rst, sfr_wr, sfr_rd, move_wr,
    input wire logic flash_read_req, flash_read_timing_select,
    input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, move_wdata, flash_wdata_q,
    input wire logic [16:0] move_addr, flash_addr_q,
    input wire logic flash_prog_q, flash_erase_q, xdata_wr_q,
    input wire logic flash_rd_strobe_q, flash_low_power_q,
    input wire logic prefetch_engine_enable_q, block_write_enable_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // timed-mode arm, and half of the longest strobe
    sequence s_arm; flash_read_timing_select && $rose(flash_read_req); endsequence
    sequence s_half; (flash_read_timing_select && flash_rd_strobe_q) [*8]; endsequence
    a_one_cmd: assert property (move_wr |=>
        $onehot({flash_prog_q, flash_erase_q, xdata_wr_q})) else $error("move write command");
    a_no_spur: assert property (!move_wr |=>
        !(flash_prog_q || flash_erase_q || xdata_wr_q)) else $error("spurious command");
    a_addr_cap: assert property (move_wr |=>
        flash_addr_q == $past(move_addr)) else $error("flash address");
    a_data_cap: assert property (move_wr |=>
        flash_wdata_q == $past(move_wdata)) else $error("flash data");
    a_one_shot: assert property (flash_read_timing_select && flash_read_req &&
        $fell(flash_rd_strobe_q) |=> !flash_rd_strobe_q) else $error("strobe restarted");
    a_fast_strb: assert property (!$past(flash_read_timing_select) && !$past(rst) |->
        flash_rd_strobe_q == $past(flash_read_req)) else $error("fast strobe");
    a_slow_arm: assert property (s_arm |=> flash_rd_strobe_q)
        else $error("strobe not started");
    a_strb_max: assert property (s_half ##1 s_half |=> !flash_rd_strobe_q)
        else $error("strobe too long");
    a_low_pwr: assert property (flash_low_power_q == !flash_rd_strobe_q)
        else $error("low power state");
    a_psc_rsv: assert property (sfr_rd && sfr_addr == 8'h8f |=>
        sfr_rdata_q[7:2] == 6'h00) else $error("store control reserved");
    a_per_rsv: assert property (sfr_rd && sfr_addr == 8'hbe |=>
        sfr_rdata_q[7:4] == 4'h0) else $error("period reserved");
    a_cache_wr: assert property (sfr_wr && sfr_addr == 8'he3 |=>
        block_write_enable_q == $past(sfr_wdata[0])) else $error("block write bit");
    a_rst_vals: assert property ($fell(rst) |->
        prefetch_engine_enable_q && !block_write_enable_q) else $error("cache reset");
endmodule // fpsc_chk
bind fpsc_top fpsc_chk i_fpsc_chk (.*);
`default_nettype wire

// ===== dv/fpsc_core_model.sv
// Purpose: core side issuing move writes
// Assumes: drives after the falling edge
// Notes: released lines show the inverse value
`timescale 1ns/1ps
`default_nettype none
module fpsc_core_model (
    input wire logic clk,
    output var logic move_wr,
    output var logic [16:0] move_addr,
    output var logic [7:0] move_wdata
);
    // idle until the first request
    initial move_wr = 1'b0;
    // one write held across its taking edge
    task automatic mv(input logic [16:0] a, input logic [7:0] d);
        @(negedge clk);
        move_wr = 1'b1;
        move_addr = a;
        move_wdata = d;
        @(negedge clk);
        move_wr = 1'b0;
        move_addr = ~a;
        move_wdata = ~d;
    endtask
endmodule // fpsc_core_model
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: self-checking bench for fpsc_top
// Assumes: 40 MHz clk, inputs move on the falling edge
// Notes: random move targets from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0;
    logic flash_read_req = 0, flash_read_timing_select = 0;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, d;
    logic [16:0] a;
    logic [3:0] p;
    wire logic [7:0] sfr_rdata_q, move_wdata, flash_wdata_q;
    wire logic [16:0] move_addr, flash_addr_q;
    wire logic move_wr, flash_prog_q, flash_erase_q, xdata_wr_q, flash_rd_strobe_q;
    wire logic flash_low_power_q, prefetch_engine_enable_q, block_write_enable_q;
    int checks = 0, n_mismatch = 0, cyc = 0, m, k, n;
    fpsc_top i_fpsc_top (
        .clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
        .move_wr(move_wr), .move_addr(move_addr), .move_wdata(move_wdata),
        .flash_read_req(flash_read_req),
        .flash_read_timing_select(flash_read_timing_select),
        .flash_prog_q(flash_prog_q), .flash_erase_q(flash_erase_q),
        .flash_addr_q(flash_addr_q), .flash_wdata_q(flash_wdata_q),
        .xdata_wr_q(xdata_wr_q), .flash_rd_strobe_q(flash_rd_strobe_q),
        .flash_low_power_q(flash_low_power_q),
        .prefetch_engine_enable_q(prefetch_engine_enable_q),
        .block_write_enable_q(block_write_enable_q)
    );
    fpsc_core_model i_fpsc_core_model (
        .clk(clk), .move_wr(move_wr), .move_addr(move_addr), .move_wdata(move_wdata)
    );
    // clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    task automatic chk(input string nm, input logic [16:0] s, input logic [16:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic sw(input logic [7:0] ad, input logic [7:0] wd);
        @(negedge clk);
        {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, ad, wd};
        @(negedge clk);
        sfr_wr = 0;
    endtask
    task automatic sr(input logic [7:0] ad, input logic [7:0] e);
        @(negedge clk);
        {sfr_rd, sfr_addr} = {1'b1, ad};
        @(negedge clk);
        sfr_rd = 0;
        chk("rdata", sfr_rdata_q, e);
    endtask
    function automatic logic [16:0] exp_op(input int md);
        return (md == 3) ? 17'h4 : (md == 1) ? 17'h2 : 17'h1;
    endfunction
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (checks > 0 && n_mismatch == 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h1fb6d773));
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 0;
        chk("pf", prefetch_engine_enable_q, 1);
        sr(8'h8f, 8'h00);
        sr(8'hbe, 8'h0f);
        sr(8'he3, 8'h20);
        sr(8'h00, 8'h00);
        sw(8'h8f, 8'hff);
        sr(8'h8f, 8'h03);
        // erase runs before program, same location
        a = 17'($urandom);
        for (m = 3; m >= 0; m--) begin
            sw(8'h8f, 8'(m));
            d = 8'($urandom);
            i_fpsc_core_model.mv(a, d);
            chk("op", {flash_erase_q, flash_prog_q, xdata_wr_q}, exp_op(m));
            if (m[0] == 1'b0) chk("noflash", {flash_erase_q, flash_prog_q}, 0);
            chk("fa", flash_addr_q, a);
            chk("fd", flash_wdata_q, d);
        end
        sw(8'he3, 8'hff);
        sr(8'he3, 8'h21);
        sw(8'he3, 8'h00);
        chk("pf", prefetch_engine_enable_q, 0);
        chk("bw", block_write_enable_q, 0);
        // mid-run reset brings cache and period fields home
        rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        chk("pf", prefetch_engine_enable_q, 1);
        sr(8'hbe, 8'h0f);
        sw(8'hbe, 8'h00);
        flash_read_req = 1;
        repeat (20) @(negedge clk);
        chk("fast", flash_rd_strobe_q, 1);
        flash_read_req = 0;
        @(negedge clk);
        chk("fastoff", flash_rd_strobe_q, 0);
        flash_read_timing_select = 1;
        for (k = 0; k < 3; k++) begin
            p = (k == 0) ? 4'h0 : (k == 1) ? 4'($urandom) : 4'hf;
            sw(8'hbe, {4'ha, p});
            sr(8'hbe, {4'h0, p});
            flash_read_req = 1;
            n = 0;
            @(negedge clk);
            while (flash_rd_strobe_q === 1'b1 && n < 40) begin
                n++;
                @(negedge clk);
            end
            chk("width", 17'(n), {13'h0, p} + 17'h1);
            chk("lp", flash_low_power_q, 1);
            repeat (2) @(negedge clk);
            chk("oneshot", flash_rd_strobe_q, 0);
            flash_read_req = 0;
        end
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
